// ===== rcr_buck_chan.sv
// Step-down channel: control bits, two voltage codes, fault detect
`timescale 1ns/1ps
module rcr_buck_chan #(
  parameter bit HAS_CODE = 1'b1
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       wr_ctrl_i,
  input  wire logic       wr_pri_i,
  input  wire logic       wr_sec_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       select_pin_i,
  input  wire logic       pgood_i,
  output logic            enable_o,
  output logic            phase_o,
  output logic [5:0]      vcode_o,
  output logic            fault_o,
  output logic [7:0]      ctrl_rd_o,
  output logic [7:0]      pri_rd_o,
  output logic [7:0]      sec_rd_o
);

  logic       on_q, on_d, ph_q, ph_d, al_q, al_d, pg_q, pg_d, ft_q, ft_d;
  logic [5:0] pri_q, pri_d, sec_q, sec_d, act_q, act_d;

  // Next state of the channel
  always_comb
  begin
    on_d  = wr_ctrl_i ? wdata_i[rcr_pkg::CTRL_ON_BIT]    : on_q;
    ph_d  = wr_ctrl_i ? wdata_i[rcr_pkg::CTRL_PHASE_BIT] : ph_q;
    al_d  = wr_ctrl_i ? wdata_i[rcr_pkg::CTRL_ALLOW_BIT] : al_q;
    pri_d = (HAS_CODE && wr_pri_i) ? wdata_i[5:0] : pri_q;
    sec_d = (HAS_CODE && wr_sec_i) ? wdata_i[5:0] : sec_q;
    act_d = select_pin_i ? sec_q : pri_q;
    pg_d  = pgood_i;
    ft_d  = pg_q & ~pgood_i & al_q;
  end

  // Channel registers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      on_q  <= rcr_pkg::RST_ON;
      ph_q  <= rcr_pkg::RST_PHASE;
      al_q  <= rcr_pkg::RST_ALLOW;
      pri_q <= rcr_pkg::RST_CODE;
      sec_q <= rcr_pkg::RST_CODE;
      act_q <= rcr_pkg::RST_CODE;
      pg_q  <= 1'b0;
      ft_q  <= 1'b0;
    end
    else
    begin
      on_q  <= on_d;
      ph_q  <= ph_d;
      al_q  <= al_d;
      pri_q <= pri_d;
      sec_q <= sec_d;
      act_q <= act_d;
      pg_q  <= pg_d;
      ft_q  <= ft_d;
    end
  end

  // Outputs and read images, reserved bits fixed
  assign enable_o  = on_q;
  assign phase_o   = ph_q;
  assign vcode_o   = HAS_CODE ? act_q : rcr_pkg::RST_CODE;
  assign fault_o   = ft_q;
  assign ctrl_rd_o = {on_q, 4'h0, ph_q, al_q, pg_q};
  assign pri_rd_o  = {2'b00, pri_q};
  assign sec_rd_o  = {2'b00, sec_q};

endmodule

// ===== rcr_host_model.sv
// Host model: register strobe master and voltage select pin driver
`timescale 1ns/1ps
module rcr_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_rd_o,
  output logic            select_pin_o
);
  // Idle bus at time zero
  initial
  begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o    = 1'b0;
    select_pin_o = 1'b0;
  end
  // One-cycle write, data scrambled once released
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~d;
  endtask
  // One-cycle read, data taken while valid
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge clk_i);
    reg_rd_o   = 1'b0;
    d          = reg_rvalid_i ? reg_rdata_i : 8'hxx;
  endtask
  // Chooses which buck code is active
  task automatic set_select(input logic lvl);
    @(negedge clk_i);
    select_pin_o = lvl;
  endtask
endmodule

// ===== rcr_ldo_chan.sv
// Low-dropout channel: enable, one voltage code, discharge, fault detect
`timescale 1ns/1ps
module rcr_ldo_chan (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       wr_ctrl_i,
  input  wire logic       wr_volt_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       pgood_i,
  output logic            enable_o,
  output logic            discharge_o,
  output logic [5:0]      vcode_o,
  output logic            fault_o,
  output logic [7:0]      ctrl_rd_o,
  output logic [7:0]      volt_rd_o
);

  logic       on_q, on_d, ds_q, ds_d, al_q, al_d, pg_q, pg_d, ft_q, ft_d;
  logic [5:0] code_q, code_d;

  // Next state of the channel
  always_comb
  begin
    on_d   = wr_ctrl_i ? wdata_i[rcr_pkg::CTRL_ON_BIT]    : on_q;
    ds_d   = wr_ctrl_i ? wdata_i[rcr_pkg::CTRL_DISCHARGE_BIT]
                       : ds_q;
    al_d   = wr_ctrl_i ? wdata_i[rcr_pkg::CTRL_ALLOW_BIT] : al_q;
    code_d = wr_volt_i ? wdata_i[5:0] : code_q;
    pg_d   = pgood_i;
    ft_d   = pg_q & ~pgood_i & al_q;
  end

  // Channel registers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      on_q   <= rcr_pkg::RST_ON;
      ds_q   <= rcr_pkg::RST_DISCHARGE;
      al_q   <= rcr_pkg::RST_ALLOW;
      code_q <= rcr_pkg::RST_CODE;
      pg_q   <= 1'b0;
      ft_q   <= 1'b0;
    end
    else
    begin
      on_q   <= on_d;
      ds_q   <= ds_d;
      al_q   <= al_d;
      code_q <= code_d;
      pg_q   <= pg_d;
      ft_q   <= ft_d;
    end
  end

  // Discharge only while shut down
  assign discharge_o = ds_q & ~on_q;
  assign enable_o    = on_q;
  assign vcode_o     = code_q;
  assign fault_o     = ft_q;
  assign ctrl_rd_o   = {on_q, 4'h0, ds_q, al_q, pg_q};
  assign volt_rd_o   = {2'b00, code_q};

endmodule

// ===== rcr_pkg.sv
// Package: register map, field positions and reset values
package rcr_pkg;

  // Channel counts and code width
  localparam int NUM_BUCK = 4;
  localparam int NUM_LDO  = 2;
  localparam int CODE_W   = 6;

  // Buck register offsets, channel 1 first
  localparam logic [3:0][7:0] BUCK_CTRL_OFS = {8'h42, 8'h32, 8'h22, 8'h12};
  localparam logic [3:0][7:0] BUCK_PRI_OFS  = {8'h40, 8'h30, 8'h20, 8'h00};
  localparam logic [3:0][7:0] BUCK_SEC_OFS  = {8'h41, 8'h31, 8'h21, 8'h00};
  // Channel 1 has no voltage registers in this bank
  localparam logic [3:0]      BUCK_HAS_CODE = 4'he;

  // LDO register offsets, channel 5 first
  localparam logic [1:0][7:0] LDO_VOLT_OFS = {8'h58, 8'h50};
  localparam logic [1:0][7:0] LDO_CTRL_OFS = {8'h59, 8'h51};

  // Control register field positions
  localparam int CTRL_ON_BIT        = 7;
  localparam int CTRL_PHASE_BIT     = 2;
  localparam int CTRL_DISCHARGE_BIT = 2;
  localparam int CTRL_ALLOW_BIT     = 1;
  localparam int CTRL_PGOOD_BIT     = 0;

  // Reset values of the writable fields
  localparam logic                RST_ON        = 1'b0;
  localparam logic                RST_PHASE     = 1'b0;
  localparam logic                RST_DISCHARGE = 1'b0;
  localparam logic                RST_ALLOW     = 1'b0;
  localparam logic [CODE_W-1:0]   RST_CODE      = 6'h00;

  // Value of unmapped and reserved read bits
  localparam logic [7:0] RD_FILL = 8'h00;

endpackage

// ===== rcr_regs.sv
// Regulator control register bank: decode, channels, read-back
`timescale 1ns/1ps
module rcr_regs #(
  parameter int NUM_BUCK = rcr_pkg::NUM_BUCK,
  parameter int NUM_LDO  = rcr_pkg::NUM_LDO
) (
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic [7:0]                  reg_addr_i,
  input  wire logic                        reg_wr_i,
  input  wire logic [7:0]                  reg_wdata_i,
  input  wire logic                        reg_rd_i,
  output logic      [7:0]                  reg_rdata_o,
  output logic                             reg_rvalid_o,
  input  wire logic                        voltage_select_pin_i,
  input  wire logic [NUM_BUCK-1:0]         buck_pgood_i,
  input  wire logic [NUM_LDO-1:0]          ldo_pgood_i,
  output logic      [NUM_BUCK-1:0]         buck_enable_o,
  output logic      [NUM_BUCK-1:0]         buck_phase_shift_o,
  output logic      [NUM_BUCK-1:0][5:0]    buck_vcode_o,
  output logic      [NUM_LDO-1:0]          ldo_enable_o,
  output logic      [NUM_LDO-1:0]          output_discharge_enable_o,
  output logic      [NUM_LDO-1:0][5:0]     ldo_voltage_code_o,
  output logic                             fault_irq_o
);

  // Per-register write strobes, read images and channel faults
  logic [NUM_BUCK-1:0]      bwr_ctrl, bwr_pri, bwr_sec, bflt;
  logic [NUM_BUCK-1:0][7:0] brd_ctrl, brd_pri, brd_sec;
  logic [NUM_LDO-1:0]       lwr_ctrl, lwr_volt, lflt;
  logic [NUM_LDO-1:0][7:0]  lrd_ctrl, lrd_volt;

  // Read path and interrupt state
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;
  logic       irq_q, irq_d;

  // Step-down channels
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BUCK; gb++)
    begin : g_buck
      // Address decode of this channel's registers
      assign bwr_ctrl[gb] = reg_wr_i &&
                            (reg_addr_i == rcr_pkg::BUCK_CTRL_OFS[gb]);
      assign bwr_pri[gb]  = reg_wr_i && rcr_pkg::BUCK_HAS_CODE[gb] &&
                            (reg_addr_i == rcr_pkg::BUCK_PRI_OFS[gb]);
      assign bwr_sec[gb]  = reg_wr_i && rcr_pkg::BUCK_HAS_CODE[gb] &&
                            (reg_addr_i == rcr_pkg::BUCK_SEC_OFS[gb]);

      rcr_buck_chan #(
        .HAS_CODE (rcr_pkg::BUCK_HAS_CODE[gb])
      ) u_buck (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .wr_ctrl_i (bwr_ctrl[gb]),
        .wr_pri_i  (bwr_pri[gb]),
        .wr_sec_i  (bwr_sec[gb]),
        .wdata_i   (reg_wdata_i),
        .select_pin_i (voltage_select_pin_i),
        .pgood_i   (buck_pgood_i[gb]),
        .enable_o  (buck_enable_o[gb]),
        .phase_o   (buck_phase_shift_o[gb]),
        .vcode_o   (buck_vcode_o[gb]),
        .fault_o   (bflt[gb]),
        .ctrl_rd_o (brd_ctrl[gb]),
        .pri_rd_o  (brd_pri[gb]),
        .sec_rd_o  (brd_sec[gb])
      );
    end
  endgenerate

  // Low-dropout channels
  genvar gl;
  generate
    for (gl = 0; gl < NUM_LDO; gl++)
    begin : g_ldo
      // Address decode of this channel's registers
      assign lwr_ctrl[gl] = reg_wr_i &&
                            (reg_addr_i == rcr_pkg::LDO_CTRL_OFS[gl]);
      assign lwr_volt[gl] = reg_wr_i &&
                            (reg_addr_i == rcr_pkg::LDO_VOLT_OFS[gl]);

      rcr_ldo_chan u_ldo (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .wr_ctrl_i   (lwr_ctrl[gl]),
        .wr_volt_i   (lwr_volt[gl]),
        .wdata_i     (reg_wdata_i),
        .pgood_i     (ldo_pgood_i[gl]),
        .enable_o    (ldo_enable_o[gl]),
        .discharge_o (output_discharge_enable_o[gl]),
        .vcode_o     (ldo_voltage_code_o[gl]),
        .fault_o     (lflt[gl]),
        .ctrl_rd_o   (lrd_ctrl[gl]),
        .volt_rd_o   (lrd_volt[gl])
      );
    end
  endgenerate

  // Read mux; unmapped addresses return the fill value
  always_comb
  begin
    rdata_d  = rdata_q;
    rvalid_d = reg_rd_i;
    if (reg_rd_i)
    begin
      rdata_d = rcr_pkg::RD_FILL;
      for (int i = 0; i < NUM_BUCK; i++)
      begin
        if (reg_addr_i == rcr_pkg::BUCK_CTRL_OFS[i])
          rdata_d = brd_ctrl[i];
        if (rcr_pkg::BUCK_HAS_CODE[i] &&
            reg_addr_i == rcr_pkg::BUCK_PRI_OFS[i])
          rdata_d = brd_pri[i];
        if (rcr_pkg::BUCK_HAS_CODE[i] &&
            reg_addr_i == rcr_pkg::BUCK_SEC_OFS[i])
          rdata_d = brd_sec[i];
      end
      for (int j = 0; j < NUM_LDO; j++)
      begin
        if (reg_addr_i == rcr_pkg::LDO_CTRL_OFS[j])
          rdata_d = lrd_ctrl[j];
        if (reg_addr_i == rcr_pkg::LDO_VOLT_OFS[j])
          rdata_d = lrd_volt[j];
      end
    end
    // One-cycle fault request from any allowed channel
    irq_d = (|bflt) | (|lflt);
  end

  // Read and interrupt registers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rdata_q  <= rcr_pkg::RD_FILL;
      rvalid_q <= 1'b0;
      irq_q    <= 1'b0;
    end
    else
    begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      irq_q    <= irq_d;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign fault_irq_o  = irq_q;

endmodule

// ===== rcr_regs_checker.sv
// Checker: port-level assertions for the regulator register bank
`timescale 1ns/1ps
module rcr_regs_checker #(
  parameter int NUM_BUCK = 4,
  parameter int NUM_LDO  = 2
) (
  input wire logic                     clk_i,
  input wire logic                     sys_rst_i,
  input wire logic [7:0]               reg_addr_i,
  input wire logic                     reg_wr_i,
  input wire logic [7:0]               reg_wdata_i,
  input wire logic                     reg_rd_i,
  input wire logic [7:0]               reg_rdata_o,
  input wire logic                     voltage_select_pin_i,
  input wire logic [NUM_BUCK-1:0]      buck_pgood_i,
  input wire logic [NUM_LDO-1:0]       ldo_pgood_i,
  input wire logic [NUM_BUCK-1:0]      buck_enable_o,
  input wire logic [NUM_BUCK-1:0]      buck_phase_shift_o,
  input wire logic [NUM_BUCK-1:0][5:0] buck_vcode_o,
  input wire logic [NUM_LDO-1:0]       output_discharge_enable_o,
  input wire logic [NUM_LDO-1:0][5:0]  ldo_voltage_code_o,
  input wire logic                     fault_irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // Write strobe at one address, and code writes held under one pin level
  sequence s_wr(logic [7:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  sequence s_code(logic [7:0] a, logic lvl);
    (s_wr(a) && voltage_select_pin_i == lvl)
      ##1 (voltage_select_pin_i == lvl && !(reg_wr_i && reg_addr_i == a))[*2];
  endsequence

  AST_ENABLE: assert property (
    s_wr(8'h22) |=> buck_enable_o[1] == $past(reg_wdata_i[7]))
    else $error("buck enable does not follow written bit");
  AST_PHASE: assert property (
    s_wr(8'h42) |=> buck_phase_shift_o[3] == $past(reg_wdata_i[2]))
    else $error("buck phase does not follow written bit");
  AST_PRIMARY: assert property (
    s_code(8'h20, 1'b0) |=> buck_vcode_o[1] == $past(reg_wdata_i[5:0], 3))
    else $error("primary code not active with select low");
  AST_SECONDARY: assert property (
    s_code(8'h31, 1'b1) |=> buck_vcode_o[2] == $past(reg_wdata_i[5:0], 3))
    else $error("secondary code not active with select high");
  AST_LDO_CODE: assert property (
    s_wr(8'h58) |=> ldo_voltage_code_o[1] == $past(reg_wdata_i[5:0]))
    else $error("ldo code does not follow written value");
  AST_DISCHARGE: assert property (
    s_wr(8'h51) |=> output_discharge_enable_o[0] ==
      ($past(reg_wdata_i[2]) && !$past(reg_wdata_i[7])))
    else $error("discharge not tied to bit and shutdown");
  AST_PGOOD: assert property (
    (reg_rd_i && reg_addr_i == 8'h12 && !$past(sys_rst_i)
      && $stable(buck_pgood_i[0]))
      |=> reg_rdata_o[0] == $past(buck_pgood_i[0]))
    else $error("power-good read bit wrong");
  AST_RESERVED: assert property (
    (reg_rd_i && reg_addr_i inside {8'h12, 8'h22, 8'h42, 8'h51, 8'h59})
      |=> reg_rdata_o[6:3] == 4'h0)
    else $error("reserved control bits not zero");
  AST_IRQ_CAUSE: assert property (
    fault_irq_o |-> (|($past(buck_pgood_i, 3) & ~$past(buck_pgood_i, 2))
      || |($past(ldo_pgood_i, 3) & ~$past(ldo_pgood_i, 2))))
    else $error("fault request without power-good fall");
endmodule

bind rcr_regs rcr_regs_checker #(.NUM_BUCK(NUM_BUCK), .NUM_LDO(NUM_LDO))
  i_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .voltage_select_pin_i(voltage_select_pin_i),
  .buck_pgood_i(buck_pgood_i), .ldo_pgood_i(ldo_pgood_i),
  .buck_enable_o(buck_enable_o), .buck_phase_shift_o(buck_phase_shift_o),
  .buck_vcode_o(buck_vcode_o), .ldo_voltage_code_o(ldo_voltage_code_o),
  .output_discharge_enable_o(output_discharge_enable_o),
  .fault_irq_o(fault_irq_o));

// ===== testbench.sv
// Testbench: register bank scenarios driven through the host model
`timescale 1ns/1ps
module testbench;
  logic            clk, rst, wr, rd, rvalid, sel_pin, irq;
  logic [7:0]      addr, wdata, rdata, v;
  logic [3:0]      b_pg, b_en, b_ph;
  logic [1:0]      l_pg, l_en, l_dis;
  logic [3:0][5:0] b_vc;
  logic [1:0][5:0] l_vc;
  int              num_errors, samples_checked, n;

  rcr_host_model h (.clk_i(clk), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
    .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd),
    .select_pin_o(sel_pin));
  rcr_regs i_dut (.clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .voltage_select_pin_i(sel_pin),
    .buck_pgood_i(b_pg),
    .ldo_pgood_i(l_pg), .buck_enable_o(b_en), .buck_phase_shift_o(b_ph),
    .buck_vcode_o(b_vc), .ldo_enable_o(l_en), .ldo_voltage_code_o(l_vc),
    .output_discharge_enable_o(l_dis), .fault_irq_o(irq));

  // Compare and count
  task automatic check(input string w, input logic [7:0] e,
                       input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  // Enable and phase per buck, reserved and status bits kept
  task automatic t_controls();
    for (int i = 0; i < 4; i++)
    begin
      h.write_reg(rcr_pkg::BUCK_CTRL_OFS[i], 8'hfe);
      check("enable", 8'h01, {7'h00, b_en[i]});
      check("phase", 8'h01, {7'h00, b_ph[i]});
      h.read_reg(rcr_pkg::BUCK_CTRL_OFS[i], v);
      check("ctrl", 8'h86, v);
      h.write_reg(rcr_pkg::BUCK_CTRL_OFS[i], 8'h00);
      check("disable", 8'h00, {7'h00, b_en[i]});
      check("in phase", 8'h00, {7'h00, b_ph[i]});
    end
  endtask
  // Code chosen by the select pin, reserved code bits, unmapped read
  task automatic t_codes();
    h.write_reg(8'h20, 8'hd5);
    repeat (3) @(negedge clk);
    check("primary", 8'h15, {2'b00, b_vc[1]});
    h.set_select(1'b1);
    h.write_reg(8'h31, 8'hea);
    repeat (3) @(negedge clk);
    check("secondary", 8'h2a, {2'b00, b_vc[2]});
    h.read_reg(8'h31, v);
    check("code read", 8'h2a, v);
    h.read_reg(8'h10, v);
    check("unmapped", 8'h00, v);
    h.set_select(1'b0);
  endtask
  // LDO code and discharge only in shutdown
  task automatic t_ldo();
    for (int j = 0; j < 2; j++)
    begin
      h.write_reg(rcr_pkg::LDO_VOLT_OFS[j], 8'hc7);
      check("ldo code", 8'h07, {2'b00, l_vc[j]});
      h.write_reg(rcr_pkg::LDO_CTRL_OFS[j], 8'h04);
      check("discharge", 8'h01, {7'h00, l_dis[j]});
      h.write_reg(rcr_pkg::LDO_CTRL_OFS[j], 8'h84);
      check("discharge on", 8'h02, {6'h00, l_en[j], l_dis[j]});
    end
  endtask
  // Count fault requests after a power-good fall on buck 1
  task automatic t_fault(input logic [7:0] c, input int exp_n);
    h.write_reg(8'h12, c);
    b_pg[0] = 1'b1;
    repeat (3) @(negedge clk);
    h.read_reg(8'h12, v);
    check("pgood", c | 8'h01, v);
    b_pg[0] = 1'b0;
    n = 0;
    repeat (6)
    begin
      @(negedge clk);
      n += int'(irq === 1'b1);
    end
    check("irq count", exp_n[7:0], n[7:0]);
  endtask
  // Verdict
  task automatic close_out();
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Main sequence
  initial
  begin
    rst = 1'b1;
    b_pg = 4'h0;
    l_pg = 2'h0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_controls();
    t_codes();
    t_ldo();
    t_fault(8'h02, 1);
    t_fault(8'h00, 0);
    close_out();
  end
  // Watchdog
  initial
  begin
    #80000;
    num_errors++;
    close_out();
  end
endmodule
